// File: logic/hcl_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "hcl_params.svh"
// Notes on behaviour
// - Memory addressed with two address bytes
// - One fixed read command format only
// - Marker D0 loads identifiers only
// - Marker D2 loads bytes zero to twelve
// - Identifiers low byte first, high next
// - Byte seven holds two filter nibbles
// - Upper nibble usable ports, count derived
// - Lower nibble detachable ports, reported
// - Byte nine is upstream current budget
// - Byte ten is controller current draw
// - Byte eleven is supply settle delay
// - Bit seven accepts zero descriptor type
// - Bit five limits hub to 12 Mbit
// - Bit four darkens indicators, clears b7
// - Bit two selects shared supply switching
// - Bit one advertises one translator only
// - Bit zero suppresses packet end at EOF1
// - Bit six ignored entirely
// - Characteristics b1..b0: 00 shared, 01 per-port
module hcl_loader #(
	parameter int IMG_DEPTH = 16
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	output logic SPI_SCK,
	output logic SPI_CS_N,
	output logic SPI_MOSI,
	input wire logic SPI_MISO,
	input wire logic DESC_REQ_VALID,
	input wire logic [7:0] DESC_REQ_TYPE,
	output logic DESC_ANSWER,
	output logic DESC_STALL,
	input wire logic [3:0] PORT_LED_REQ,
	output logic [3:0] PORT_LED,
	output logic LOAD_DONE,
	output logic [15:0] VENDOR_ID,
	output logic [15:0] PRODUCT_ID,
	output logic [15:0] DEVICE_ID,
	output logic [3:0] ENABLED_PORT_FAULT_FILTER_MS,
	output logic [3:0] DISABLED_PORT_FAULT_FILTER_MS,
	output logic [3:0] USABLE_PORT_MASK,
	output logic [3:0] DETACHABLE_PORT_MASK,
	output logic [2:0] PORT_COUNT,
	output logic [7:0] UPSTREAM_CURRENT_BUDGET,
	output logic [7:0] CONTROLLER_CURRENT_DRAW,
	output logic [7:0] SUPPLY_SETTLE_DELAY,
	output logic [15:0] HUB_CHARACTERISTICS,
	output logic [7:0] TT_PROTOCOL_CODE,
	output logic ACCEPT_ZERO_DESCRIPTOR_TYPE,
	output logic LIMIT_TO_12MBIT,
	output logic DISABLE_STATUS_LEDS,
	output logic SHARED_SUPPLY_SWITCHING,
	output logic ONE_TRANSLATOR_MODE,
	output logic SUPPRESS_FRAME_END_PACKET_END
);
	localparam logic [23:0] READ_FRAME = {`HCL_RD_CMD, `HCL_START_ADDR};

	if (IMG_DEPTH < `HCL_IMG_BYTES || IMG_DEPTH > 16) begin : g_bad_depth
		$error("hcl_loader: IMG_DEPTH must be 13..16");
	end

	hcl_pkg::hcl_state_e state;
	hcl_pkg::hcl_fmt_e fmt;
	logic miso_s;
	logic reload;
	logic [7:0] sck_half;
	logic [7:0] div_cnt;
	logic [23:0] cmd_shift;
	logic [4:0] cmd_cnt;
	logic [2:0] bit_cnt;
	logic [3:0] byte_idx;
	logic [3:0] last_idx;
	logic [6:0] rx;
	logic bad_marker;
	logic [7:0] opts;
	logic shifting;
	logic half_end;
	logic fall_edge;
	logic byte_done;
	logic [7:0] byte_val;
	logic [3:0] next_last;
	logic [7:0] img_rdata;
	logic access;
	logic hit;
	logic [31:0] rd_mux;
	logic wr_take;

	hcl_sync u_miso_sync (
		.clk(CLK),
		.rst(SYS_RST),
		.d(SPI_MISO),
		.q(miso_s)
	);

	hcl_cfg_mem #(.WIDTH(8), .DEPTH(IMG_DEPTH), .AW(4)) u_img (
		.clk(CLK),
		.we(byte_done),
		.waddr(byte_idx),
		.wdata(byte_val),
		.raddr(PADDR[5:2]),
		.rdata(img_rdata)
	);

	assign shifting = (state == hcl_pkg::HCL_ST_CMD) || (state == hcl_pkg::HCL_ST_DATA);
	assign half_end = div_cnt >= (sck_half - 8'h01);
	// Bits move at the end of the high phase; MISO is sampled there too
	assign fall_edge = shifting && half_end && SPI_SCK;
	assign byte_done = fall_edge && (state == hcl_pkg::HCL_ST_DATA) && (bit_cnt == 3'h7);
	assign byte_val = {rx, miso_s};

	always_comb begin
		next_last = last_idx;
		if (byte_idx == 4'h0) begin
			if (byte_val == `HCL_MARK_ID) begin
				next_last = `HCL_LAST_ID_BYTE;
			end else if (byte_val == `HCL_MARK_FULL) begin
				next_last = `HCL_LAST_FULL_BYTE;
			end else begin
				next_last = 4'h0;
			end
		end
	end

	// Sequencer: starts on reset release or software reload
	always_ff @(posedge CLK) begin
		if (SYS_RST || reload) begin
			state <= hcl_pkg::HCL_ST_START;
		end else begin
			case (state)
				hcl_pkg::HCL_ST_START: begin
					state <= hcl_pkg::HCL_ST_CMD;
				end
				hcl_pkg::HCL_ST_CMD: begin
					if (fall_edge && cmd_cnt == `HCL_CMD_BITS) begin
						state <= hcl_pkg::HCL_ST_DATA;
					end
				end
				hcl_pkg::HCL_ST_DATA: begin
					if (byte_done && byte_idx == next_last) begin
						state <= hcl_pkg::HCL_ST_DONE;
					end
				end
				hcl_pkg::HCL_ST_DONE: begin
					state <= hcl_pkg::HCL_ST_DONE;
				end
				default: begin
					state <= hcl_pkg::HCL_ST_START;
				end
			endcase
		end
	end

	// Serial clock divider, mode 0
	always_ff @(posedge CLK) begin
		if (SYS_RST || reload || !shifting) begin
			div_cnt <= 8'h00;
			SPI_SCK <= 1'b0;
		end else if (half_end) begin
			div_cnt <= 8'h00;
			SPI_SCK <= ~SPI_SCK;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			SPI_CS_N <= 1'b1;
		end else begin
			SPI_CS_N <= !((state == hcl_pkg::HCL_ST_START) || shifting) || reload;
		end
	end

	// Read command then a two-byte start address
	always_ff @(posedge CLK) begin
		if (SYS_RST || state == hcl_pkg::HCL_ST_START) begin
			cmd_shift <= READ_FRAME;
			cmd_cnt <= 5'h00;
			SPI_MOSI <= SYS_RST ? 1'b0 : READ_FRAME[23];
		end else if (state == hcl_pkg::HCL_ST_CMD && fall_edge) begin
			cmd_shift <= {cmd_shift[22:0], 1'b0};
			cmd_cnt <= cmd_cnt + 5'h01;
			SPI_MOSI <= (cmd_cnt == `HCL_CMD_BITS) ? 1'b0 : cmd_shift[22];
		end else if (state != hcl_pkg::HCL_ST_CMD) begin
			SPI_MOSI <= 1'b0;
		end
	end

	// Sequential receive from address zero
	always_ff @(posedge CLK) begin
		if (SYS_RST || state == hcl_pkg::HCL_ST_START) begin
			bit_cnt <= 3'h0;
			byte_idx <= 4'h0;
			rx <= 7'h00;
		end else if (state == hcl_pkg::HCL_ST_DATA && fall_edge) begin
			bit_cnt <= bit_cnt + 3'h1;
			rx <= {rx[5:0], miso_s};
			if (bit_cnt == 3'h7) begin
				byte_idx <= byte_idx + 4'h1;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || state == hcl_pkg::HCL_ST_START) begin
			fmt <= hcl_pkg::HCL_FMT_NONE;
			last_idx <= 4'h0;
			bad_marker <= 1'b0;
		end else if (byte_done && byte_idx == 4'h0) begin
			last_idx <= next_last;
			bad_marker <= (next_last == 4'h0);
			if (byte_val == `HCL_MARK_ID) begin
				fmt <= hcl_pkg::HCL_FMT_ID;
			end else if (byte_val == `HCL_MARK_FULL) begin
				fmt <= hcl_pkg::HCL_FMT_FULL;
			end
		end
	end

	// Apply each byte as it arrives; built-in values until then
	always_ff @(posedge CLK) begin
		if (SYS_RST || reload) begin
			VENDOR_ID <= `HCL_VID_DEF;
			PRODUCT_ID <= `HCL_PID_DEF;
			DEVICE_ID <= `HCL_DID_DEF;
			{ENABLED_PORT_FAULT_FILTER_MS, DISABLED_PORT_FAULT_FILTER_MS} <= `HCL_FILTER_DEF;
			{USABLE_PORT_MASK, DETACHABLE_PORT_MASK} <= `HCL_PORTS_DEF;
			UPSTREAM_CURRENT_BUDGET <= `HCL_BUDGET_DEF;
			CONTROLLER_CURRENT_DRAW <= `HCL_CTRLCUR_DEF;
			SUPPLY_SETTLE_DELAY <= `HCL_SETTLE_DEF;
			opts <= `HCL_OPTS_DEF;
		end else if (byte_done && fmt != hcl_pkg::HCL_FMT_NONE) begin
			case (byte_idx)
				`HCL_B_VID_LO: VENDOR_ID[7:0] <= byte_val;
				`HCL_B_VID_HI: VENDOR_ID[15:8] <= byte_val;
				`HCL_B_PID_LO: PRODUCT_ID[7:0] <= byte_val;
				`HCL_B_PID_HI: PRODUCT_ID[15:8] <= byte_val;
				`HCL_B_DID_LO: DEVICE_ID[7:0] <= byte_val;
				`HCL_B_DID_HI: DEVICE_ID[15:8] <= byte_val;
				default: begin
					if (fmt == hcl_pkg::HCL_FMT_FULL) begin
						case (byte_idx)
							`HCL_B_FILTER: begin
								ENABLED_PORT_FAULT_FILTER_MS <= byte_val[7:4];
								DISABLED_PORT_FAULT_FILTER_MS <= byte_val[3:0];
							end
							`HCL_B_PORTS: begin
								USABLE_PORT_MASK <= byte_val[7:4];
								DETACHABLE_PORT_MASK <= byte_val[3:0];
							end
							`HCL_B_BUDGET: UPSTREAM_CURRENT_BUDGET <= byte_val;
							`HCL_B_CTRLCUR: CONTROLLER_CURRENT_DRAW <= byte_val;
							`HCL_B_SETTLE: SUPPLY_SETTLE_DELAY <= byte_val;
							`HCL_B_OPTS: opts <= byte_val;
							default: opts <= opts;
						endcase
					end
				end
			endcase
		end
	end

	// Option bits; bits six and three have no effect
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ACCEPT_ZERO_DESCRIPTOR_TYPE <= 1'b0;
			LIMIT_TO_12MBIT <= 1'b0;
			DISABLE_STATUS_LEDS <= 1'b0;
			SHARED_SUPPLY_SWITCHING <= 1'b0;
			ONE_TRANSLATOR_MODE <= 1'b0;
			SUPPRESS_FRAME_END_PACKET_END <= 1'b0;
		end else begin
			ACCEPT_ZERO_DESCRIPTOR_TYPE <= opts[`HCL_OPT_ZERO_DESC];
			LIMIT_TO_12MBIT <= opts[`HCL_OPT_FS_ONLY];
			DISABLE_STATUS_LEDS <= opts[`HCL_OPT_NO_LEDS];
			SHARED_SUPPLY_SWITCHING <= opts[`HCL_OPT_GANG];
			ONE_TRANSLATOR_MODE <= opts[`HCL_OPT_ONE_TT];
			SUPPRESS_FRAME_END_PACKET_END <= opts[`HCL_OPT_NO_EOP];
		end
	end

	// Descriptor words derived from the loaded options and the usable port mask
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			HUB_CHARACTERISTICS <= `HCL_HUBCHAR_DEF;
			TT_PROTOCOL_CODE <= `HCL_PROTO_MULTI;
			PORT_COUNT <= 3'h4;
		end else begin
			HUB_CHARACTERISTICS <= `HCL_HUBCHAR_DEF;
			if (SHARED_SUPPLY_SWITCHING) begin
				HUB_CHARACTERISTICS[1:0] <= 2'b00;
				HUB_CHARACTERISTICS[4:3] <= 2'b00;
			end
			if (DISABLE_STATUS_LEDS) begin
				HUB_CHARACTERISTICS[7] <= 1'b0;
			end
			TT_PROTOCOL_CODE <= ONE_TRANSLATOR_MODE ? `HCL_PROTO_SINGLE : `HCL_PROTO_MULTI;
			PORT_COUNT <= 3'($countones(USABLE_PORT_MASK));
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			LOAD_DONE <= 1'b0;
		end else begin
			LOAD_DONE <= (state == hcl_pkg::HCL_ST_DONE) && !reload;
		end
	end

	// Descriptor-type decision for get-hub-descriptor
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			DESC_ANSWER <= 1'b0;
			DESC_STALL <= 1'b0;
		end else begin
			DESC_ANSWER <= DESC_REQ_VALID && ((DESC_REQ_TYPE == `HCL_DESC_HUB) ||
				(DESC_REQ_TYPE == `HCL_DESC_ZERO && ACCEPT_ZERO_DESCRIPTOR_TYPE));
			DESC_STALL <= DESC_REQ_VALID && !((DESC_REQ_TYPE == `HCL_DESC_HUB) ||
				(DESC_REQ_TYPE == `HCL_DESC_ZERO && ACCEPT_ZERO_DESCRIPTOR_TYPE));
		end
	end

	for (genvar p = 0; p < 4; p++) begin : g_led
		always_ff @(posedge CLK) begin
			if (SYS_RST) begin
				PORT_LED[p] <= 1'b0;
			end else begin
				PORT_LED[p] <= PORT_LED_REQ[p] && !DISABLE_STATUS_LEDS;
			end
		end
	end

	// APB slave: one wait state on every access
	assign access = PSEL && PENABLE;
	assign wr_take = access && PREADY && PWRITE;

	always_comb begin
		rd_mux = 32'h0000_0000;
		hit = 1'b1;
		case (PADDR)
			`HCL_A_CTRL: rd_mux = 32'h0000_0000;
			`HCL_A_DIV: rd_mux = {24'h00_0000, sck_half};
			`HCL_A_STATUS: rd_mux = {27'h000_0000, bad_marker, fmt, shifting, LOAD_DONE};
			`HCL_A_IDS: rd_mux = {PRODUCT_ID, VENDOR_ID};
			`HCL_A_DID: rd_mux = {16'h0000, DEVICE_ID};
			default: begin
				if (PADDR >= `HCL_A_IMG && PADDR <= `HCL_A_IMG_LAST && PADDR[1:0] == 2'b00) begin
					rd_mux = {24'h00_0000, img_rdata};
				end else begin
					hit = 1'b0;
				end
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0000_0000;
			PSLVERR <= 1'b0;
		end else begin
			PREADY <= access && !PREADY;
			if (access && !PREADY) begin
				PRDATA <= PWRITE ? 32'h0000_0000 : rd_mux;
				PSLVERR <= !hit;
			end else begin
				PSLVERR <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			reload <= 1'b0;
			sck_half <= `HCL_SCK_HALF_DEF;
		end else begin
			reload <= wr_take && PADDR == `HCL_A_CTRL && PWDATA[0];
			if (wr_take && PADDR == `HCL_A_DIV && PWDATA[7:0] >= `HCL_SCK_HALF_MIN) begin
				sck_half <= PWDATA[7:0];
			end
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (SYS_RST);

	sequence s_bad_first_byte;
		byte_done && byte_idx == 4'h0 && byte_val != `HCL_MARK_ID &&
			byte_val != `HCL_MARK_FULL && !reload;
	endsequence
	sequence s_ends_with_defaults;
		##2 LOAD_DONE && VENDOR_ID == `HCL_VID_DEF && SPI_CS_N;
	endsequence

	chk_frame_start: assert property ($fell(SPI_CS_N) |->
		cmd_shift == READ_FRAME && SPI_MOSI == READ_FRAME[23])
		else $error("read frame does not start with command and zero address");
	chk_hub_held: assert property (LOAD_DONE |-> SPI_CS_N && !shifting)
		else $error("hub released while memory still selected");
	chk_vid_high: assert property ((byte_done && byte_idx == `HCL_B_VID_HI && !reload)
		|=> VENDOR_ID[15:8] == $past(byte_val))
		else $error("vendor high byte not taken from byte two");
	chk_filter_nib: assert property ((byte_done && byte_idx == `HCL_B_FILTER && !reload
		&& fmt == hcl_pkg::HCL_FMT_FULL) |=> ENABLED_PORT_FAULT_FILTER_MS == $past(byte_val[7:4])
		&& DISABLED_PORT_FAULT_FILTER_MS == $past(byte_val[3:0]))
		else $error("filter nibbles misplaced");
	chk_port_count: assert property (LOAD_DONE |-> PORT_COUNT == 3'($countones(USABLE_PORT_MASK)))
		else $error("port count disagrees with usable mask");
	chk_zero_desc: assert property ((DESC_REQ_VALID && DESC_REQ_TYPE == `HCL_DESC_ZERO
		&& !ACCEPT_ZERO_DESCRIPTOR_TYPE) |=> DESC_STALL && !DESC_ANSWER)
		else $error("zero descriptor type not stalled");
	chk_leds_dark: assert property (DISABLE_STATUS_LEDS [*2] |-> PORT_LED == 4'h0
		&& !HUB_CHARACTERISTICS[7])
		else $error("indicators lit while disabled");
	chk_power_mode: assert property ((SHARED_SUPPLY_SWITCHING ##1 1'b1) |->
		HUB_CHARACTERISTICS[1:0] == 2'b00 && HUB_CHARACTERISTICS[4:3] == 2'b00)
		else $error("shared switching not reported");
	chk_bad_marker: assert property (s_bad_first_byte |-> s_ends_with_defaults)
		else $error("unknown marker did not end load with defaults");
endmodule
`default_nettype wire

// File: inc/hcl_params.svh
`ifndef HCL_PARAMS_SVH
`define HCL_PARAMS_SVH

// Serial memory read frame
`define HCL_RD_CMD 8'h03
`define HCL_START_ADDR 16'h0000
`define HCL_CMD_BITS 5'h17
`define HCL_MARK_ID 8'hD0
`define HCL_MARK_FULL 8'hD2
`define HCL_LAST_ID_BYTE 4'h6
`define HCL_LAST_FULL_BYTE 4'hC
`define HCL_IMG_BYTES 13

// Image byte positions
`define HCL_B_VID_LO 4'h1
`define HCL_B_VID_HI 4'h2
`define HCL_B_PID_LO 4'h3
`define HCL_B_PID_HI 4'h4
`define HCL_B_DID_LO 4'h5
`define HCL_B_DID_HI 4'h6
`define HCL_B_FILTER 4'h7
`define HCL_B_PORTS 4'h8
`define HCL_B_BUDGET 4'h9
`define HCL_B_CTRLCUR 4'hA
`define HCL_B_SETTLE 4'hB
`define HCL_B_OPTS 4'hC

// Option bit positions
`define HCL_OPT_ZERO_DESC 7
`define HCL_OPT_FS_ONLY 5
`define HCL_OPT_NO_LEDS 4
`define HCL_OPT_GANG 2
`define HCL_OPT_ONE_TT 1
`define HCL_OPT_NO_EOP 0

// Built-in values; identifier values are arbitrary
`define HCL_VID_DEF 16'h1234
`define HCL_PID_DEF 16'h5678
`define HCL_DID_DEF 16'h0100
`define HCL_FILTER_DEF 8'h88
`define HCL_PORTS_DEF 8'hFF
`define HCL_BUDGET_DEF 8'h32
`define HCL_CTRLCUR_DEF 8'h64
`define HCL_SETTLE_DEF 8'h32
`define HCL_OPTS_DEF 8'h00
`define HCL_HUBCHAR_DEF 16'h0089
`define HCL_DESC_HUB 8'h29
`define HCL_DESC_ZERO 8'h00
`define HCL_PROTO_SINGLE 8'h01
`define HCL_PROTO_MULTI 8'h02

// APB map
`define HCL_A_CTRL 8'h00
`define HCL_A_DIV 8'h04
`define HCL_A_STATUS 8'h08
`define HCL_A_IDS 8'h0C
`define HCL_A_DID 8'h10
`define HCL_A_IMG 8'h40
`define HCL_A_IMG_LAST 8'h70

// Serial clock half period in core cycles
`define HCL_SCK_HALF_DEF 8'h04
`define HCL_SCK_HALF_MIN 8'h03

`endif

// File: inc/hcl_pkg.sv
`default_nettype none
package hcl_pkg;
	typedef enum logic [2:0] {
		HCL_ST_START = 3'b000,
		HCL_ST_CMD = 3'b001,
		HCL_ST_DATA = 3'b010,
		HCL_ST_DONE = 3'b011
	} hcl_state_e;

	typedef enum logic [1:0] {
		HCL_FMT_NONE = 2'b00,
		HCL_FMT_ID = 2'b01,
		HCL_FMT_FULL = 2'b10
	} hcl_fmt_e;
endpackage
`default_nettype wire

// File: logic/hcl_sync.sv
`timescale 1ns/1ps
`default_nettype none
module hcl_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);
	logic meta;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta <= 1'b0;
			q <= 1'b0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule
`default_nettype wire

// File: logic/hcl_cfg_mem.sv
`timescale 1ns/1ps
`default_nettype none
module hcl_cfg_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [WIDTH-1:0] rdata
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH > (1 << AW)) begin : g_bad_depth
		$error("hcl_cfg_mem: DEPTH exceeds address range");
	end

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk) begin
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

// File: dv/hcl_eeprom_model.sv
`timescale 1ns/1ps
`default_nettype none
module hcl_eeprom_model (
	input wire logic sck,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso
);
	logic [7:0] mem [0:15];
	logic [23:0] hdr;
	int nb;
	initial begin
		miso = 1'b0;
		nb = 0;
		hdr = '0;
	end
	always @(negedge cs_n) begin
		nb = 0;
	end
	// Command byte then two address bytes, sampled on rising clock
	always @(posedge sck) begin
		if (!cs_n) begin
			if (nb < 24) begin
				hdr = {hdr[22:0], mosi};
			end
			nb = nb + 1;
		end
	end
	// Answers only the one read format; otherwise the line toggles on every falling clock
	always @(negedge sck) begin
		if (!cs_n && nb >= 24 && hdr[23:16] == 8'h03) begin
			miso <= mem[4'(hdr[15:0] + (nb - 24) / 8)][7 - ((nb - 24) % 8)];
		end else begin
			miso <= ~miso;
		end
	end
	// Released line must not hold its last level
	always @(posedge cs_n) begin
		miso <= ~miso;
	end
endmodule
`default_nettype wire

// File: dv/tb_hcl_loader.sv
`timescale 1ns/1ps
`default_nettype none
`include "hcl_params.svh"
module tb_hcl_loader;
	logic clk, rst, psel, pen, pwr, sck, csn, mosi, miso, rdy, serr, dv, ans, stl, done;
	logic [7:0] pa, dt, ucb, ccd, ssd, tt;
	logic [31:0] pwd, prd;
	logic [3:0] lr, led, efm, dfm, upm, dpm;
	logic [2:0] pc;
	logic [15:0] vid, pid, did, hc;
	logic [5:0] opt;
	logic [7:0] mk [0:4];
	logic [7:0] ops [0:4];
	logic [31:0] r;
	logic e;
	int err_count, checked;
	hcl_loader dut (
		.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
		.PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(serr), .SPI_SCK(sck),
		.SPI_CS_N(csn), .SPI_MOSI(mosi), .SPI_MISO(miso), .DESC_REQ_VALID(dv),
		.DESC_REQ_TYPE(dt), .DESC_ANSWER(ans), .DESC_STALL(stl), .PORT_LED_REQ(lr),
		.PORT_LED(led), .LOAD_DONE(done), .VENDOR_ID(vid), .PRODUCT_ID(pid), .DEVICE_ID(did),
		.ENABLED_PORT_FAULT_FILTER_MS(efm), .DISABLED_PORT_FAULT_FILTER_MS(dfm),
		.USABLE_PORT_MASK(upm), .DETACHABLE_PORT_MASK(dpm), .PORT_COUNT(pc),
		.UPSTREAM_CURRENT_BUDGET(ucb), .CONTROLLER_CURRENT_DRAW(ccd),
		.SUPPLY_SETTLE_DELAY(ssd), .HUB_CHARACTERISTICS(hc), .TT_PROTOCOL_CODE(tt),
		.ACCEPT_ZERO_DESCRIPTOR_TYPE(opt[5]), .LIMIT_TO_12MBIT(opt[4]),
		.DISABLE_STATUS_LEDS(opt[3]), .SHARED_SUPPLY_SWITCHING(opt[2]),
		.ONE_TRANSLATOR_MODE(opt[1]), .SUPPRESS_FRAME_END_PACKET_END(opt[0])
	);
	hcl_eeprom_model eep (.sck(sck), .cs_n(csn), .mosi(mosi), .miso(miso));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic print_verdict;
		$display("checks=%0d errors=%0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		pa <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (rdy !== 1'b1 && n < 50);
		chk(32'(n < 50), 32'h0000_0001);
		if (n >= 50) print_verdict();
		r = prd;
		e = serr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		chk(32'(n < 5000), 32'h0000_0001);
		if (n >= 5000) print_verdict();
	endtask
	task automatic fill(input logic [7:0] m, input logic [7:0] o);
		for (int i = 1; i < 16; i++) eep.mem[i] = 8'($urandom);
		eep.mem[0] = m;
		eep.mem[12] = o & 8'hF7;
	endtask
	task automatic desc(input logic [7:0] t, input logic z, input logic n);
		logic [3:0] q;
		logic a;
		q = 4'($urandom);
		a = (t == `HCL_DESC_HUB) || (t == `HCL_DESC_ZERO && z);
		@(posedge clk);
		dv <= 1'b1;
		dt <= t;
		lr <= q;
		@(posedge clk);
		dv <= 1'b0;
		@(posedge clk);
		chk(32'({ans, stl}), 32'({a, !a}));
		chk(32'(led), 32'(q & {4{!n}}));
	endtask
	task automatic verify;
		logic [7:0] x [0:12];
		logic [7:0] o;
		int f;
		x = '{8'h00, 8'(`HCL_VID_DEF), 8'(`HCL_VID_DEF >> 8), 8'(`HCL_PID_DEF),
			8'(`HCL_PID_DEF >> 8), 8'(`HCL_DID_DEF), 8'(`HCL_DID_DEF >> 8), 8'h88, 8'hFF,
			8'h32, 8'h64, 8'h32, 8'h00};
		f = (eep.mem[0] == `HCL_MARK_ID) ? 1 : (eep.mem[0] == `HCL_MARK_FULL) ? 2 : 0;
		for (int i = 1; i < 13; i++) begin
			if ((f == 1 && i < 7) || f == 2) x[i] = eep.mem[i];
		end
		o = x[12];
		chk(32'(vid), 32'({x[2], x[1]}));
		chk(32'(pid), 32'({x[4], x[3]}));
		chk(32'(did), 32'({x[6], x[5]}));
		chk(32'({efm, dfm}), 32'(x[7]));
		chk(32'({upm, dpm}), 32'(x[8]));
		chk(32'(pc), 32'($countones(x[8][7:4])));
		chk(32'({ucb, ccd, ssd}), 32'({x[9], x[10], x[11]}));
		chk(32'(opt), 32'({o[7], o[5], o[4], o[2], o[1], o[0]}));
		chk(32'(hc), 32'({8'h00, ~o[4], 3'b000, ~o[2], 2'b00, ~o[2]}));
		chk(32'(tt), o[1] ? 32'h0000_0001 : 32'h0000_0002);
		chk(32'(eep.hdr), 32'({`HCL_RD_CMD, `HCL_START_ADDR}));
		apb(1'b0, `HCL_A_STATUS, 32'h0);
		chk(r, 32'({f == 0, 2'(f), 1'b0, 1'b1}));
		apb(1'b0, `HCL_A_IMG, 32'h0);
		chk(r, 32'(eep.mem[0]));
		desc(`HCL_DESC_HUB, o[7], o[4]);
		desc(`HCL_DESC_ZERO, o[7], o[4]);
		desc(8'h5A, o[7], o[4]);
	endtask
	initial begin
		#200_000;
		err_count++;
		print_verdict();
	end
	initial begin
		rst = 1'b1;
		{psel, pen, pwr, dv} = 4'h0;
		pa = 8'h00;
		dt = 8'h00;
		pwd = 32'h0;
		lr = 4'h0;
		mk = '{8'hD2, 8'hD0, 8'hD2, 8'hD1, 8'hD2};
		ops = '{8'h00, 8'hFF, 8'hF7, 8'h00, 8'h00};
		void'($urandom(32'h64bd4159));
		fill(8'h55, 8'h00);
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		wait_done();
		verify();
		apb(1'b0, 8'h20, 32'h0);
		chk(32'(e), 32'h0000_0001);
		apb(1'b1, `HCL_A_DIV, 32'h0000_0002);
		apb(1'b0, `HCL_A_DIV, 32'h0);
		chk(r, 32'h0000_0004);
		apb(1'b1, `HCL_A_DIV, 32'h0000_0003);
		apb(1'b0, `HCL_A_DIV, 32'h0);
		chk(r, 32'h0000_0003);
		for (int k = 0; k < 5; k++) begin
			fill(mk[k], (k == 4) ? 8'($urandom) : ops[k]);
			apb(1'b1, `HCL_A_CTRL, 32'h0000_0001);
			@(posedge clk);
			@(posedge clk);
			chk(32'(done), 32'h0000_0000);
			wait_done();
			verify();
		end
		print_verdict();
	end
endmodule
`default_nettype wire
